// >>> rtl/aprl_pkg.sv
// shared constants and types for the absolute position readout link
package aprl_pkg;
  localparam int          CLK_HZ        = 40_000_000;
  localparam int          READY_MAX_US  = 2000;
  localparam int          READY_MAX_CYC = CLK_HZ / 1_000_000 * READY_MAX_US;
  localparam int          FRAME_BITS    = 56;
  localparam int          STEPS         = 28;
  localparam logic [5:0]  STEP_LAST     = 6'h1b;
  localparam int          FIFO_DEPTH    = 8;
  localparam logic [2:0]  STATUS_ZERO   = 3'h0;
  localparam logic [31:0] POS_RESET     = 32'h0;

  typedef struct packed {
    logic        overflow;
    logic        lostOverspeed;
    logic        lostBattery;
    logic        lowBattery;
    logic        noBattery;
  } aprl_status_t;

  typedef struct packed {
    logic signed [31:0] position;
    logic [7:0]         status;
    logic [7:0]         alarmCode;
    logic [7:0]         checksum;
  } aprl_frame_t;

  typedef enum logic [2:0] {
    ST_IDLE, ST_LOAD, ST_READY, ST_SHIFT, ST_WAITLOW, ST_DONE
  } aprl_state_t;
endpackage

// >>> rtl/aprl_fifo.sv
// parameterised valid/ready fifo
`timescale 1ns/1ps
module aprl_fifo #(
  parameter int WIDTH = 56,
  parameter int DEPTH = 8
) (
  input  wire logic             mclk,
  input  wire logic             rst,
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  outValid,
  input  wire logic             outReady,
  output logic      [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wrPtr_r, rdPtr_r;
  logic [AW:0]      count_r;
  logic             push, pop;

  assign inReady  = (count_r != (AW+1)'(DEPTH));
  assign outValid = (count_r != '0);
  assign outData  = mem[rdPtr_r];
  assign push     = inValid && inReady;
  assign pop      = outValid && outReady;

  always_ff @(posedge mclk) begin
    if (rst) begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
      count_r <= '0;
    end else begin
      if (push) begin
        mem[wrPtr_r] <= inData;
        wrPtr_r      <= (wrPtr_r == AW'(DEPTH-1)) ? '0 : wrPtr_r + 1'b1;
      end
      if (pop)
        rdPtr_r <= (rdPtr_r == AW'(DEPTH-1)) ? '0 : rdPtr_r + 1'b1;
      if (push && !pop)
        count_r <= count_r + 1'b1;
      else if (pop && !push)
        count_r <= count_r - 1'b1;
    end
  end
endmodule

// >>> rtl/aprl_top.sv
// absolute position alarm handling and two-bit readout link
`timescale 1ns/1ps
module aprl_top (
  input  wire logic               mclk,
  input  wire logic               rst,
  input  wire logic               absEnable,
  input  wire logic               positionLost,
  input  wire logic               postLossPulsePolicy,
  input  wire logic               pulseIn,
  input  wire logic               positionRequestIn,
  input  wire logic               alarmClearIn,
  input  wire logic               positionPresetIn,
  input  wire logic signed [31:0] positionIn,
  input  wire logic               positionValid,
  input  wire aprl_pkg::aprl_status_t statusIn,
  input  wire logic [7:0]         alarmCodeIn,
  input  wire logic               readyNormal,
  input  wire logic               torqueLimitedNormal,
  input  wire logic               zeroSpeedNormal,
  output logic                    dataReadyOut,
  output logic                    dataLowBitOut,
  output logic                    dataHighBitOut,
  output logic                    lossAlarm,
  output logic                    warningOut,
  output logic                    pulseEnable,
  output logic                    positionZero,
  output logic                    deviationClear,
  output logic                    sampleDropped
);
  // two-stage synchronisers for the pulse, request, clear and preset pins
  logic [3:0] sA_r, sB_r;
  logic       reqS, ckS, clrS, preS, reqD_r, clrD_r;
  always_ff @(posedge mclk) begin
    if (rst) begin
      sA_r   <= 4'h0;
      sB_r   <= 4'h0;
      reqD_r <= 1'b0;
      clrD_r <= 1'b0;
    end else begin
      sA_r   <= {positionPresetIn, alarmClearIn, positionRequestIn, pulseIn};
      sB_r   <= sA_r;
      reqD_r <= reqS;
      clrD_r <= clrS;
    end
  end
  assign reqS = sB_r[1];
  assign ckS  = sB_r[2];
  assign clrS = sB_r[2];
  assign preS = sB_r[3];
  logic pulseS;
  assign pulseS = sB_r[0];
  logic reqRise, clrFall;
  assign reqRise = reqS && !reqD_r;
  // clear input is the link clock while requested
  assign clrFall = !clrS && clrD_r && !reqS;

  // alarm and policy state
  logic alarm_r, alarm_nxt, pen_r, pen_nxt;
  logic policy_r, policyCaught_r, zero_r, zero_nxt;
  always_comb begin
    alarm_nxt = alarm_r;
    pen_nxt   = pen_r;
    zero_nxt  = 1'b0;
    if (absEnable && positionLost)
      alarm_nxt = 1'b1;
    else if (!pen_r && pulseS && !alarm_r)
      alarm_nxt = 1'b1;
    else if (clrFall && alarm_r) begin
      alarm_nxt = 1'b0;
      zero_nxt  = 1'b1;
      pen_nxt   = policy_r;
    end
    if (alarm_nxt)
      pen_nxt = 1'b0;
    // default policy waits for request rise
    else if (reqRise && !alarm_r)
      pen_nxt = 1'b1;
  end

  logic warn_r, warn_nxt;
  always_comb begin
    warn_nxt = warn_r;
    if (alarm_nxt)
      warn_nxt = 1'b1;
    else if (preS && !alarm_r)
      warn_nxt = 1'b0;
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      alarm_r        <= 1'b0;
      pen_r          <= 1'b1;
      zero_r         <= 1'b0;
      warn_r         <= 1'b0;
      policyCaught_r <= 1'b0;
      policy_r       <= 1'b0;
    end else begin
      alarm_r <= alarm_nxt;
      pen_r   <= pen_nxt;
      zero_r  <= zero_nxt;
      warn_r  <= warn_nxt;
      // policy latched once after reset release
      if (!policyCaught_r) begin
        policy_r       <= postLossPulsePolicy;
        policyCaught_r <= 1'b1;
      end
    end
  end

  // current position snapshot with zero on alarm reset
  logic signed [31:0] pos_r;
  always_ff @(posedge mclk) begin
    if (rst)
      pos_r <= aprl_pkg::POS_RESET;
    else if (zero_r)
      pos_r <= aprl_pkg::POS_RESET;
    else if (positionValid)
      pos_r <= positionIn;
  end

  // frame assembly
  aprl_pkg::aprl_frame_t fr;
  logic [7:0] statusByte, sum;
  always_comb begin
    statusByte = {aprl_pkg::STATUS_ZERO, statusIn.noBattery,
                  statusIn.lowBattery, statusIn.lostBattery,
                  statusIn.lostOverspeed, statusIn.overflow};
    sum = pos_r[31:24] + pos_r[23:16] + pos_r[15:8] + pos_r[7:0]
          + statusByte + alarmCodeIn;
    fr.position  = pos_r;
    fr.status    = statusByte;
    fr.alarmCode = alarmCodeIn;
    fr.checksum  = sum;
  end

  // snapshot fifo; captures come only in idle and the link pops each at once, so it holds one frame at most
  logic                  fifoInReady, fifoOutValid, fifoPop;
  logic [aprl_pkg::FRAME_BITS-1:0] fifoOut;
  logic                  capture;
  aprl_fifo #(.WIDTH(aprl_pkg::FRAME_BITS), .DEPTH(aprl_pkg::FIFO_DEPTH))
    uFifo (
      .mclk    (mclk),
      .rst     (rst),
      .inValid (capture),
      .inReady (fifoInReady),
      .inData  (fr),
      .outValid(fifoOutValid),
      .outReady(fifoPop),
      .outData (fifoOut)
    );

  // readout handshake
  aprl_pkg::aprl_state_t st_r, st_nxt;
  logic [55:0] sh_r, sh_nxt;
  logic [5:0]  step_r, step_nxt;
  logic        rdy_r, rdy_nxt, lo_r, lo_nxt, hi_r, hi_nxt;
  always_comb begin
    st_nxt   = st_r;
    sh_nxt   = sh_r;
    step_nxt = step_r;
    rdy_nxt  = rdy_r;
    lo_nxt   = lo_r;
    hi_nxt   = hi_r;
    capture  = 1'b0;
    fifoPop  = 1'b0;
    case (st_r)
      aprl_pkg::ST_IDLE: begin
        // request taken in any motion state
        if (reqRise && absEnable) begin
          capture = 1'b1;
          st_nxt  = aprl_pkg::ST_LOAD;
        end
      end
      aprl_pkg::ST_LOAD: begin
        if (fifoOutValid) begin
          sh_nxt   = fifoOut;
          fifoPop  = 1'b1;
          step_nxt = 6'h0;
          // ready two cycles after edge, far inside 2 ms
          rdy_nxt  = 1'b1;
          st_nxt   = aprl_pkg::ST_READY;
        end
      end
      aprl_pkg::ST_READY: begin
        // clock only trusted once ready is up
        if (ckS) begin
          // next two msbs out, then drop ready
          hi_nxt  = sh_r[55];
          lo_nxt  = sh_r[54];
          sh_nxt  = {sh_r[53:0], 2'b00};
          st_nxt  = aprl_pkg::ST_SHIFT;
        end
      end
      aprl_pkg::ST_SHIFT: begin
        rdy_nxt = 1'b0;
        st_nxt  = aprl_pkg::ST_WAITLOW;
      end
      aprl_pkg::ST_WAITLOW: begin
        // ready returns on clock low; 28 steps
        if (!ckS) begin
          if (step_r == aprl_pkg::STEP_LAST)
            st_nxt = aprl_pkg::ST_DONE;
          else begin
            step_nxt = step_r + 6'h1;
            rdy_nxt  = 1'b1;
            st_nxt   = aprl_pkg::ST_READY;
          end
        end
      end
      aprl_pkg::ST_DONE: ;
      default: st_nxt = aprl_pkg::ST_IDLE;
    endcase
    // early drop aborts with ready low
    if (!reqS && st_r != aprl_pkg::ST_IDLE) begin
      st_nxt  = aprl_pkg::ST_IDLE;
      rdy_nxt = 1'b0;
      lo_nxt  = 1'b0;
      hi_nxt  = 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      st_r   <= aprl_pkg::ST_IDLE;
      sh_r   <= 56'h0;
      step_r <= 6'h0;
      rdy_r  <= 1'b0;
      lo_r   <= 1'b0;
      hi_r   <= 1'b0;
    end else begin
      st_r   <= st_nxt;
      sh_r   <= sh_nxt;
      step_r <= step_nxt;
      rdy_r  <= rdy_nxt;
      lo_r   <= lo_nxt;
      hi_r   <= hi_nxt;
    end
  end

  // output muxing registered; normal functions suspended while requested
  always_ff @(posedge mclk) begin
    if (rst) begin
      dataReadyOut   <= 1'b0;
      dataLowBitOut  <= 1'b0;
      dataHighBitOut <= 1'b0;
      lossAlarm      <= 1'b0;
      warningOut     <= 1'b0;
      pulseEnable    <= 1'b0;
      positionZero   <= 1'b0;
      deviationClear <= 1'b0;
      sampleDropped  <= 1'b0;
    end else begin
      dataReadyOut   <= reqS ? rdy_nxt : readyNormal;
      dataLowBitOut  <= reqS ? lo_nxt  : torqueLimitedNormal;
      dataHighBitOut <= reqS ? hi_nxt  : zeroSpeedNormal;
      lossAlarm      <= alarm_nxt;
      warningOut     <= warn_nxt;
      pulseEnable    <= pen_nxt;
      positionZero   <= zero_nxt;
      deviationClear <= clrS && !reqS;
      sampleDropped  <= capture && !fifoInReady;
    end
  end

  chk_ready_after_req: assert property (
    @(posedge mclk) disable iff (rst)
    $rose(reqS) && absEnable && st_r == aprl_pkg::ST_IDLE
      |-> ##[1:4] (rdy_r || !reqS))
    else $error("ready not raised after request");
  chk_ready_drop_ck: assert property (@(posedge mclk) disable iff (rst)
    st_r == aprl_pkg::ST_READY && ckS && reqS |-> ##2 !rdy_r)
    else $error("ready not dropped after clock high");
  chk_abort_ready_low: assert property (
    @(posedge mclk) disable iff (rst)
    !reqS |=> !rdy_r)
    else $error("ready high without request");
  chk_alarm_clear_zero: assert property (
    @(posedge mclk) disable iff (rst)
    $fell(alarm_r) |-> zero_r ##1 pos_r == 32'h0)
    else $error("position not zeroed on alarm reset");
  chk_warn_holds: assert property (@(posedge mclk) disable iff (rst)
    $fell(alarm_r) |-> warn_r)
    else $error("warning dropped with alarm");
  chk_loss_raises: assert property (@(posedge mclk) disable iff (rst)
    absEnable && positionLost |=> alarm_r)
    else $error("loss did not raise alarm");
  chk_step_bound: assert property (@(posedge mclk) disable iff (rst)
    step_r <= aprl_pkg::STEP_LAST)
    else $error("step count past 28");
  chk_policy_stable: assert property (@(posedge mclk) disable iff (rst)
    policyCaught_r && $past(policyCaught_r) |-> $stable(policy_r))
    else $error("policy changed without power cycle");
endmodule

// >>> bench/aprl_ctrl_model.sv
// controller model that reads position frames over the two-bit link
`timescale 1ns/1ps
module aprl_ctrl_model (
  input  wire logic        dataReadyOut,
  input  wire logic        dataLowBitOut,
  input  wire logic        dataHighBitOut,
  output logic             positionRequestIn,
  output logic             transferClockIn,
  output logic [55:0]      frame,
  output logic             frameDone
);
  initial begin
    positionRequestIn = 1'b0;
    transferClockIn = 1'b0;
    frame = 56'h0;
    frameDone = 1'b0;
  end
  // bounded poll so a dead ready line cannot hang the run
  // whole-period steps keep every pin change off the sampling edge
  task automatic await(input logic lvl, output logic ok);
    int n;
    n = 0;
    while (dataReadyOut !== lvl && n < 800) begin
      #25;
      n++;
    end
    ok = (dataReadyOut === lvl);
  endtask
  task automatic read_frame(input int stopAt, input int slow, output logic ok);
    logic [7:0] sum;
    #13;
    positionRequestIn = 1'b1;
    ok = 1'b1;
    // ready still shows its normal function until the request is through
    #100;
    for (int i = 0; i < 28 && ok; i++) begin
      await(1'b1, ok);
      #(100 * slow);
      transferClockIn = 1'b1;
      await(1'b0, ok);
      frame = {frame[53:0], dataHighBitOut, dataLowBitOut};
      #100;
      transferClockIn = 1'b0;
      if (i == stopAt) break;
    end
    #100;
    positionRequestIn = 1'b0;
    // recompute the six-byte sum, drop a frame that disagrees
    sum = frame[55:48] + frame[47:40] + frame[39:32] + frame[31:24]
          + frame[23:16] + frame[15:8];
    if (stopAt >= 28 && sum != frame[7:0]) ok = 1'b0;
    frameDone = (stopAt >= 28) && ok;
    #100;
    frameDone = 1'b0;
  endtask
endmodule

// >>> bench/aprl_top_tb.sv
// self-checking bench for the readout link and loss alarm
`timescale 1ns/1ps
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin err_count++; \
  $display("[FAIL] %0t got %h exp %h", $time, (a), (e)); end end
module aprl_top_tb;
  logic        mclk = 1'b0;
  logic        rst = 1'b1;
  logic        absEnable = 1'b0;
  logic        positionLost = 1'b0;
  logic        policy = 1'b0;
  logic        pulseIn = 1'b0;
  logic        clrPin = 1'b0;
  logic        presetPin = 1'b0;
  logic [31:0] position = 32'h0;
  logic        posValid = 1'b0;
  logic [4:0]  status = 5'h0;
  logic [7:0]  alarmCode = 8'h0;
  logic [2:0]  normal = 3'h0;
  logic        dataReadyOut, dataLowBitOut, dataHighBitOut, lossAlarm;
  logic        warningOut, pulseEnable, positionZero, deviationClear;
  logic        req, linkCk, frameDone, sampleDropped;
  logic [2:0]  lines;
  logic [55:0] frame;
  logic [55:0] expq[$];
  int          err_count = 0;
  int          check_count = 0;
  int          seed = 32'h3cc5;
  int          cycles = 0;
  int          zeroSeen = 0;
  int          clrSeen = 0;
  int          dropSeen = 0;
  int          c0;
  always #12.5 mclk = ~mclk;
  assign lines = {dataReadyOut, dataLowBitOut, dataHighBitOut};
  aprl_top DUT (.mclk(mclk), .rst(rst), .absEnable(absEnable),
    .positionLost(positionLost), .postLossPulsePolicy(policy),
    .pulseIn(pulseIn), .positionRequestIn(req),
    .alarmClearIn(linkCk | clrPin), .positionPresetIn(presetPin),
    .positionIn(position), .positionValid(posValid),
    .statusIn(aprl_pkg::aprl_status_t'(status)), .alarmCodeIn(alarmCode),
    .readyNormal(normal[2]), .torqueLimitedNormal(normal[1]),
    .zeroSpeedNormal(normal[0]), .dataReadyOut(dataReadyOut),
    .dataLowBitOut(dataLowBitOut), .dataHighBitOut(dataHighBitOut),
    .lossAlarm(lossAlarm), .warningOut(warningOut),
    .pulseEnable(pulseEnable), .positionZero(positionZero),
    .deviationClear(deviationClear), .sampleDropped(sampleDropped));
  aprl_ctrl_model PARTNER (.dataReadyOut(dataReadyOut),
    .dataLowBitOut(dataLowBitOut), .dataHighBitOut(dataHighBitOut),
    .positionRequestIn(req), .transferClockIn(linkCk), .frame(frame),
    .frameDone(frameDone));
  task automatic report_and_stop();
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  always @(posedge mclk) begin
    cycles++;
    if (positionZero === 1'b1) zeroSeen++;
    if (deviationClear === 1'b1) clrSeen++;
    if (sampleDropped === 1'b1) dropSeen++;
    // ceiling well above the seven readouts and the alarm sequences
    if (cycles == 40000) begin
      err_count++;
      report_and_stop();
    end
  end
  always @(posedge frameDone) begin : score
    logic [55:0] e;
    e = expq.size() ? expq.pop_front() : 56'h0;
    `CHK(frame, e)
  end
  function automatic logic [55:0] mk(logic [31:0] p);
    logic [7:0] s;
    logic [7:0] c;
    s = {3'h0, status[0], status[1], status[2], status[3], status[4]};
    c = p[31:24] + p[23:16] + p[15:8] + p[7:0] + s + alarmCode;
    return {p, s, alarmCode, c};
  endfunction
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #2;
  endtask
  task automatic readout(input int stopAt, input int slow,
                         input logic [31:0] p);
    logic ok;
    if (stopAt >= 28) expq.push_back(mk(p));
    PARTNER.read_frame(stopAt, slow, ok);
    `CHK(ok, 1'b1);
    tick(6);
  endtask
  task automatic alarm_cycle(input logic expEn);
    int z0;
    positionLost = 1'b1;
    tick(5);
    `CHK(lossAlarm, 1'b1);
    positionLost = 1'b0;
    z0 = zeroSeen;
    clrPin = 1'b1;
    tick(5);
    `CHK(lossAlarm, 1'b1);
    `CHK(deviationClear, 1'b1);
    clrPin = 1'b0;
    tick(6);
    `CHK({lossAlarm, warningOut, pulseEnable}, {2'b01, expEn});
    `CHK(zeroSeen != z0, 1'b1);
  endtask
  initial begin
    tick(8);
    rst = 1'b0;
    tick(3);
    absEnable = 1'b1;
    for (int i = 0; i < 4; i++) begin
      // a negative first position exercises the sign bits
      position = (i == 0) ? 32'hffffcfc7 : $random(seed);
      status = 5'($random(seed));
      alarmCode = 8'($random(seed));
      normal = 3'h7;
      posValid = 1'b1;
      tick(1);
      posValid = 1'b0;
      c0 = clrSeen;
      readout(28, i % 2, position);
      `CHK(clrSeen, c0);
      normal = 3'($random(seed));
      tick(4);
      `CHK(lines, normal);
    end
    normal = 3'h0;
    readout(5, 0, position);
    `CHK(lines, 3'h0);
    readout(28, 1, position);
    alarm_cycle(1'b0);
    pulseIn = 1'b1;
    tick(5);
    pulseIn = 1'b0;
    `CHK(lossAlarm, 1'b1);
    clrPin = 1'b1;
    tick(5);
    clrPin = 1'b0;
    tick(6);
    readout(28, 0, 32'h0);
    `CHK({pulseEnable, warningOut}, 2'b11);
    presetPin = 1'b1;
    tick(5);
    presetPin = 1'b0;
    tick(5);
    `CHK(warningOut, 1'b0);
    policy = 1'b1;
    alarm_cycle(1'b0);
    rst = 1'b1;
    tick(2);
    rst = 1'b0;
    tick(3);
    alarm_cycle(1'b1);
    `CHK(expq.size(), 0);
    `CHK(dropSeen, 0);
    report_and_stop();
  end
endmodule
